// File: rtl/ctmc_pkg.sv
// Constants, register map and state types of the CAN transceiver mode controller
package ctmc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int T_STARTUP_NS = 1000;
  localparam int T_UV_DET_NS = 500;
  localparam int T_UV_SLEEP_NS = 1000;
  localparam int STARTUP_CYC = (T_STARTUP_NS * CLK_MHZ + 999) / 1000;
  localparam int UV_DET_CYC = (T_UV_DET_NS * CLK_MHZ + 999) / 1000;
  localparam int UV_SLEEP_CYC = (T_UV_SLEEP_NS * CLK_MHZ + 999) / 1000;
  localparam int UV_CYC = UV_DET_CYC + UV_SLEEP_CYC;
  localparam int TMR_W = 12;
  localparam int NSYNC = 11;
  localparam int SPI_FRAME_BITS = 16;
  localparam int SPI_BYTE_BITS = 8;

  ////////////////////////////////////////////////////////////////////////////////
  localparam logic [6:0] ADDR_MODE = 7'h01;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_WAKE_CFG = 7'h04;
  localparam logic [6:0] ADDR_XCVR_CTRL = 7'h05;
  localparam logic [6:0] ADDR_EVENTS = 7'h06;
  localparam logic [2:0] MC_SLEEP = 3'h1;
  localparam logic [2:0] MC_STANDBY = 3'h4;
  localparam logic [2:0] MC_NORMAL = 3'h7;
  localparam int STAT_CAUSE_BIT = 7;
  localparam int STAT_WARN_BIT = 6;
  localparam int STAT_NYN_BIT = 5;
  localparam int CFG_BUS_WAKE_BIT = 0;
  localparam int CFG_SEL_WAKE_BIT = 1;
  localparam int CFG_RISE_BIT = 2;
  localparam int CFG_FALL_BIT = 3;
  localparam int CFG_WARN_IE_BIT = 4;
  localparam int EVT_WAKE_BIT = 0;
  localparam int EVT_WARN_BIT = 1;
  localparam int EVT_SPI_FAILURE_EVENT_BIT = 2;
  localparam logic [1:0] TMF_OFFLINE = 2'h0;
  localparam logic [1:0] TMF_ACTIVE_UV = 2'h1;
  localparam logic [1:0] TMF_ACTIVE = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {MD_OFF, MD_STANDBY, MD_NORMAL, MD_SLEEP, MD_OVERTEMP} ctmc_mode_e;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic wake_pin_p;
    ctmc_mode_e mode;
    logic [TMR_W-1:0] tmr;
    logic bus_wake_en;
    logic sel_wake_en;
    logic rise_en;
    logic fall_en;
    logic warn_ie;
    logic [1:0] tmf;
    logic wake_pend;
    logic warn_flag;
    logic spi_failure_event_flag;
    logic cause;
    logic warn_stat;
    logic nyn;
    logic rxd;
    logic inh_oe_n;
    logic tx_en;
    logic rx_en;
    logic bus_off;
    logic spi_en;
    logic sel_mode;
  } ctmc_state_s;

  localparam ctmc_state_s CTMC_STATE_RST = '{mode: MD_OFF, nyn: 1'b1, rxd: 1'b1,
    inh_oe_n: 1'b1, bus_off: 1'b1, default: '0};

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic sck_p;
    logic ssn_p;
    logic active;
    logic [4:0] cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic load;
    logic [6:0] addr;
    logic rd;
    logic [7:0] wdata;
    logic wr;
    logic cmd;
    logic fail;
  } ctmc_spi_s;

  localparam ctmc_spi_s CTMC_SPI_RST = '{s1: 3'h2, s2: 3'h2, ssn_p: 1'b1, default: '0};
endpackage

// File: rtl/ctmc_spi_port.sv
// SPI slave port: 16-bit frames of address, read flag and data
`timescale 1ns/1ps
module ctmc_spi_port import ctmc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // SPI pins
  input wire logic spi_sck,
  input wire logic spi_select_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n,
  // Register side
  input wire logic port_enable,
  input wire logic [7:0] rd_data,
  output logic [6:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_pulse,
  output logic cmd_pulse,
  output logic fail_pulse
);
  ctmc_spi_s q, d;
  logic sck_s, ssn_s, sdi_s;
  logic rise, fall;
  logic [7:0] byte_in;

  assign {sck_s, ssn_s, sdi_s} = q.s2;
  assign rise = sck_s & ~q.sck_p;
  assign fall = ~sck_s & q.sck_p;
  assign byte_in = {q.rx[6:0], sdi_s};

  always_comb begin
    d = q;
    d.s1 = {spi_sck, spi_select_n, spi_sdi};
    d.s2 = q.s1;
    d.sck_p = sck_s;
    d.ssn_p = ssn_s;
    d.wr = 1'b0;
    d.cmd = 1'b0;
    d.fail = 1'b0;
    d.load = 1'b0;
    if (q.load) begin
      d.tx = rd_data;
    end
    if (q.ssn_p && !ssn_s) begin
      // A port disabled at selection ignores the whole frame
      d.active = port_enable;
      d.cnt = '0;
      d.tx = '0;
    end else if (!ssn_s && q.active) begin
      if (rise && q.cnt < 5'(SPI_FRAME_BITS)) begin
        d.rx = byte_in;
        d.cnt = q.cnt + 5'h01;
        if (q.cnt == 5'(SPI_BYTE_BITS - 1)) begin
          d.addr = byte_in[7:1];
          d.rd = byte_in[0];
          d.load = 1'b1;
        end
        if (q.cnt == 5'(SPI_FRAME_BITS - 1)) begin
          d.wdata = byte_in;
        end
      end
      // The first data bit must stay on the pin until the next rising edge
      if (fall && q.cnt > 5'(SPI_BYTE_BITS)) begin
        d.tx = {q.tx[6:0], 1'b0};
      end
    end
    if (!q.ssn_p && ssn_s && q.active) begin
      d.active = 1'b0;
      if (q.cnt == 5'(SPI_FRAME_BITS)) begin
        d.cmd = 1'b1;
        d.wr = ~q.rd;
      end else begin
        d.fail = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= CTMC_SPI_RST;
    end else begin
      q <= d;
    end
  end

  assign spi_sdo = q.tx[7];
  assign spi_sdo_oe_n = ~(q.active & ~ssn_s);
  assign reg_addr = q.addr;
  assign wr_data = q.wdata;
  assign wr_pulse = q.wr;
  assign cmd_pulse = q.cmd;
  assign fail_pulse = q.fail;
endmodule

// File: rtl/ctmc_mode_ctrl.sv
// Operating-mode controller of a CAN transceiver with SPI registers
`timescale 1ns/1ps
module ctmc_mode_ctrl import ctmc_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Supply and temperature detectors
  input wire logic bat_above_pon,
  input wire logic bat_below_poff,
  input wire logic vcc_under,
  input wire logic io_supply_under,
  input wire logic temp_above_warn,
  input wire logic temp_above_act,
  input wire logic temp_below_rel,
  // Wake sources
  input wire logic bus_wake_std,
  input wire logic bus_wake_sel,
  input wire logic local_wake_pin,
  input wire logic selective_config_valid,
  // Bus receiver and protocol controller pins
  input wire logic bus_rx_bit,
  output logic rxd_out,
  output logic tx_enable,
  output logic rx_enable,
  output logic bus_float,
  output logic wake_selective_mode,
  // Regulator inhibit
  output logic regulator_inhibit_out,
  output logic regulator_inhibit_oe_n,
  // SPI pins
  input wire logic spi_sck,
  input wire logic spi_select_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe_n
);
  ctmc_state_s q, d;
  logic pon_s, poff_s, vcc_uv_s, io_uv_s, warn_s, act_s, rel_s;
  logic std_s, sel_s, wake_s, cfg_ok_s;
  logic [6:0] reg_addr;
  logic [7:0] wr_data, rd_data, mode_code;
  logic wr_pulse, cmd_pulse, fail_pulse;
  logic wk_bus, wk_loc, wake_set, warn_set, mode_wr, uv_now, uv_fire;
  logic [1:0] rxb_q;

  ////////////////////////////////////////////////////////////////////////////////
  ctmc_spi_port u_spi (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .spi_sck(spi_sck),
    .spi_select_n(spi_select_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe_n(spi_sdo_oe_n),
    .port_enable(q.spi_en),
    .rd_data(rd_data),
    .reg_addr(reg_addr),
    .wr_data(wr_data),
    .wr_pulse(wr_pulse),
    .cmd_pulse(cmd_pulse),
    .fail_pulse(fail_pulse)
  );

  assign {pon_s, poff_s, vcc_uv_s, io_uv_s, warn_s, act_s, rel_s, std_s, sel_s, wake_s,
    cfg_ok_s} = q.s2;

  always_comb begin
    case (q.mode)
      MD_NORMAL: mode_code = {5'h00, MC_NORMAL};
      MD_SLEEP: mode_code = {5'h00, MC_SLEEP};
      default: mode_code = {5'h00, MC_STANDBY};
    endcase
    rd_data = 8'h00;
    case (reg_addr)
      ADDR_MODE: rd_data = mode_code;
      ADDR_STATUS: begin
        rd_data[STAT_CAUSE_BIT] = q.cause;
        rd_data[STAT_WARN_BIT] = q.warn_stat;
        rd_data[STAT_NYN_BIT] = q.nyn;
      end
      ADDR_WAKE_CFG: begin
        rd_data[CFG_BUS_WAKE_BIT] = q.bus_wake_en;
        rd_data[CFG_SEL_WAKE_BIT] = q.sel_wake_en;
        rd_data[CFG_RISE_BIT] = q.rise_en;
        rd_data[CFG_FALL_BIT] = q.fall_en;
        rd_data[CFG_WARN_IE_BIT] = q.warn_ie;
      end
      ADDR_XCVR_CTRL: rd_data = {6'h00, q.tmf};
      ADDR_EVENTS: begin
        rd_data[EVT_WAKE_BIT] = q.wake_pend;
        rd_data[EVT_WARN_BIT] = q.warn_flag;
        rd_data[EVT_SPI_FAILURE_EVENT_BIT] = q.spi_failure_event_flag;
      end
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.s1 = {bat_above_pon, bat_below_poff, vcc_under, io_supply_under, temp_above_warn,
      temp_above_act, temp_below_rel, bus_wake_std, bus_wake_sel, local_wake_pin,
      selective_config_valid};
    d.s2 = q.s1;
    d.wake_pin_p = wake_s;
    d.sel_mode = q.sel_wake_en & cfg_ok_s;
    wk_bus = q.bus_wake_en & (q.sel_mode ? sel_s : std_s);
    wk_loc = (q.rise_en & wake_s & ~q.wake_pin_p) | (q.fall_en & ~wake_s & q.wake_pin_p);
    // Off and overtemperature do not see new wakes
    wake_set = (wk_bus | wk_loc) && (q.mode inside {MD_STANDBY, MD_NORMAL, MD_SLEEP});
    warn_set = warn_s & ~q.warn_stat & q.warn_ie;
    mode_wr = wr_pulse && reg_addr == ADDR_MODE;
    uv_now = vcc_uv_s | io_uv_s;
    uv_fire = uv_now && q.tmr == TMR_W'(UV_CYC - 1);
    d.warn_stat = warn_s;
    if (wr_pulse) begin
      case (reg_addr)
        ADDR_WAKE_CFG: begin
          d.bus_wake_en = wr_data[CFG_BUS_WAKE_BIT];
          d.sel_wake_en = wr_data[CFG_SEL_WAKE_BIT];
          d.rise_en = wr_data[CFG_RISE_BIT];
          d.fall_en = wr_data[CFG_FALL_BIT];
          d.warn_ie = wr_data[CFG_WARN_IE_BIT];
        end
        ADDR_XCVR_CTRL: d.tmf = wr_data[1:0];
        ADDR_EVENTS: begin
          d.wake_pend = q.wake_pend & ~wr_data[EVT_WAKE_BIT];
          d.warn_flag = q.warn_flag & ~wr_data[EVT_WARN_BIT];
          d.spi_failure_event_flag = q.spi_failure_event_flag & ~wr_data[EVT_SPI_FAILURE_EVENT_BIT];
        end
        default: ;
      endcase
    end
    // Events are applied after the clears so a same-cycle event survives
    if (wake_set) d.wake_pend = 1'b1;
    if (warn_set) d.warn_flag = 1'b1;
    if (fail_pulse) d.spi_failure_event_flag = 1'b1;
    d.tmr = '0;
    case (q.mode)
      MD_OFF: begin
        if (pon_s) begin
          if (q.tmr == TMR_W'(STARTUP_CYC - 1)) d.mode = MD_STANDBY;
          else d.tmr = q.tmr + TMR_W'(1);
        end
      end
      MD_STANDBY, MD_NORMAL: begin
        if (q.mode == MD_NORMAL && act_s) begin
          d.mode = MD_OVERTEMP;
        end else if (uv_fire) begin
          d.mode = MD_SLEEP;
          d.wake_pend = 1'b0;
          d.bus_wake_en = 1'b1;
          d.rise_en = 1'b1;
          d.fall_en = 1'b1;
          d.sel_wake_en = 1'b0;
          d.cause = 1'b1;
        end else begin
          if (uv_now) d.tmr = q.tmr + TMR_W'(1);
          if (mode_wr) begin
            case (wr_data[2:0])
              MC_NORMAL: d.mode = MD_NORMAL;
              MC_STANDBY: d.mode = MD_STANDBY;
              MC_SLEEP: begin
                // A pending wake or no wake source would strand the node
                if (!q.wake_pend && (q.bus_wake_en | q.rise_en | q.fall_en)) begin
                  d.mode = MD_SLEEP;
                  d.cause = 1'b0;
                end else begin
                  d.mode = MD_STANDBY;
                end
              end
              default: ;
            endcase
          end
        end
      end
      MD_SLEEP: begin
        if (mode_wr && wr_data[2:0] == MC_NORMAL) d.mode = MD_NORMAL;
        else if (wake_set | warn_set) d.mode = MD_STANDBY;
        else if (cmd_pulse && !io_uv_s) d.mode = MD_STANDBY;
      end
      MD_OVERTEMP: begin
        if (rel_s) d.mode = MD_STANDBY;
      end
      default: d.mode = MD_OFF;
    endcase
    if (poff_s) begin
      d.mode = MD_OFF;
      d.tmr = '0;
      d.nyn = 1'b1;
    end
    if (d.mode == MD_NORMAL) d.nyn = 1'b0;
    d.spi_en = d.mode inside {MD_STANDBY, MD_NORMAL} || (d.mode == MD_SLEEP && !io_uv_s);
    d.inh_oe_n = d.mode inside {MD_SLEEP, MD_OFF};
    d.bus_off = d.mode inside {MD_OFF, MD_OVERTEMP};
    d.rx_en = d.mode == MD_NORMAL && d.tmf != TMF_OFFLINE;
    d.tx_en = d.mode == MD_NORMAL && (d.tmf == TMF_ACTIVE ||
      (d.tmf == TMF_ACTIVE_UV && !vcc_uv_s));
    case (d.mode)
      MD_OFF: d.rxd = 1'b1;
      MD_OVERTEMP: d.rxd = ~d.wake_pend;
      MD_NORMAL: d.rxd = (d.tmf != TMF_OFFLINE) ? rxb_q[1]
                         : ~(d.wake_pend | d.warn_flag);
      default: d.rxd = ~(d.wake_pend | d.warn_flag);
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      q <= CTMC_STATE_RST;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver bit passes its own two-stage synchroniser
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxb_q <= 2'h3;
    end else begin
      rxb_q <= {rxb_q[0], bus_rx_bit};
    end
  end

  assign rxd_out = q.rxd;
  assign tx_enable = q.tx_en;
  assign rx_enable = q.rx_en;
  assign bus_float = q.bus_off;
  assign wake_selective_mode = q.sel_mode;
  assign regulator_inhibit_out = 1'b1;
  assign regulator_inhibit_oe_n = q.inh_oe_n;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  chk_off_hold: assert property (q.mode == MD_OFF && !pon_s |=> q.mode == MD_OFF)
    else $error("left off mode without power-on");
  chk_boot_time: assert property (q.mode == MD_OFF ##1 q.mode == MD_STANDBY
    |-> $past(q.tmr) == TMR_W'(STARTUP_CYC - 1))
    else $error("standby reached before startup time");
  chk_otp_release: assert property (q.mode == MD_OVERTEMP && rel_s && !poff_s
    |=> q.mode == MD_STANDBY)
    else $error("overtemperature release not taken");
  chk_otp_enter: assert property (q.mode == MD_NORMAL && act_s && !poff_s
    |=> q.mode == MD_OVERTEMP ##0 q.bus_off)
    else $error("overtemperature not entered from normal");
  chk_poff_off: assert property (poff_s |=> q.mode == MD_OFF && q.bus_off && q.inh_oe_n)
    else $error("power-off did not reach off mode");
  chk_uv_sleep: assert property (q.mode inside {MD_STANDBY, MD_NORMAL} && uv_fire && !poff_s
    && !(q.mode == MD_NORMAL && act_s) |=> q.mode == MD_SLEEP && q.cause)
    else $error("undervoltage did not force sleep");
  chk_uv_forced: assert property ($rose(q.cause) && q.mode == MD_SLEEP
    |-> q.bus_wake_en && q.rise_en && q.fall_en && !q.sel_wake_en)
    else $error("forced sleep wake settings wrong");
  chk_uv_delay: assert property (q.mode == MD_STANDBY && uv_now ##1 q.mode == MD_SLEEP
    && q.cause |-> $past(q.tmr) == TMR_W'(UV_CYC - 1))
    else $error("undervoltage sleep too early");
  chk_inh_state: assert property ((q.mode inside {MD_SLEEP, MD_OFF}) == q.inh_oe_n)
    else $error("inhibit drive does not match mode");
  chk_rxd_event: assert property (q.mode inside {MD_STANDBY, MD_SLEEP} && q.wake_pend
    |-> !rxd_out)
    else $error("receive pin not low with pending wake");
  chk_spi_gate: assert property (q.mode inside {MD_OFF, MD_OVERTEMP} |-> !q.spi_en)
    else $error("SPI enabled in off or overtemperature");
  chk_normal_cmd: assert property (mode_wr && wr_data[2:0] == MC_NORMAL && !poff_s
    && q.mode == MD_SLEEP |=> q.mode == MD_NORMAL && !q.nyn)
    else $error("normal command not taken");
  chk_otp_bus_off: assert property (q.mode == MD_OVERTEMP |-> !tx_enable && !rx_enable && bus_float)
    else $error("bus not disabled in overtemperature");
  chk_sleep_guard: assert property (mode_wr && wr_data[2:0] == MC_SLEEP && q.wake_pend && !poff_s
    && q.mode inside {MD_STANDBY, MD_NORMAL} && !uv_fire && !(q.mode == MD_NORMAL && act_s)
    |=> q.mode == MD_STANDBY)
    else $error("sleep entered with a pending wake");

  cov_normal: cover property (q.mode == MD_STANDBY ##1 q.mode == MD_NORMAL);
  cov_uv_sleep: cover property (q.mode == MD_NORMAL ##1 q.mode == MD_SLEEP && q.cause);
  cov_wake: cover property (q.mode == MD_SLEEP ##1 q.mode == MD_STANDBY);
  cov_otp: cover property (q.mode == MD_OVERTEMP ##1 q.mode == MD_STANDBY);
  cov_sel_wake: cover property (q.sel_mode && q.mode == MD_SLEEP ##1 q.mode == MD_STANDBY);
endmodule

// File: rtl/ctmc_mode_ctrl_fix.sv
// Intentionally holds no logic

// File: dv/ctmc_host_model.sv
// Host microcontroller model: SPI master sending sixteen-bit frames and cut eight-bit frames
`timescale 1ns/1ps
module ctmc_host_model (
  // SPI pins toward the device
  output logic spi_sck,
  output logic spi_select_n,
  output logic spi_sdi,
  // SPI answer from the device
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe_n
);
  logic oe_seen;

  initial begin
    spi_sck = 1'b0;
    spi_select_n = 1'b1;
    spi_sdi = 1'b1;
    oe_seen = 1'b0;
  end

  always @(negedge spi_sdo_oe_n) oe_seen = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock stands low between frames; released data line shows the inverse of its last bit
  task automatic xfer(input logic [15:0] frame, output logic [7:0] rdata);
    rdata = 8'h00;
    oe_seen = 1'b0;
    // Offset keeps pin changes away from the system clock edges
    #3;
    spi_select_n = 1'b0;
    #62.5;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = frame[i];
      #62.5;
      // A released data line reads as the inverse of what it last showed
      if (i < 8) rdata[i] = spi_sdo_oe_n ? ~spi_sdo : spi_sdo;
      spi_sck = 1'b1;
      #62.5;
      spi_sck = 1'b0;
    end
    #62.5;
    spi_select_n = 1'b1;
    spi_sdi = ~frame[0];
    // Gap covers the write latency and the minimum select-high time
    #100;
  endtask

  // Cut frame of eight bits; the device must count it as a failure
  task automatic xfer8(input logic [7:0] b);
    #3;
    spi_select_n = 1'b0;
    #62.5;
    for (int i = 7; i >= 0; i--) begin
      spi_sdi = b[i];
      #62.5;
      spi_sck = 1'b1;
      #62.5;
      spi_sck = 1'b0;
    end
    #62.5;
    spi_select_n = 1'b1;
    spi_sdi = ~b[0];
    #100;
  endtask
endmodule

// File: dv/ctmc_mode_ctrl_test.sv
// Self-checking testbench of the CAN transceiver mode controller
`timescale 1ns/1ps
module ctmc_mode_ctrl_test;
  import ctmc_pkg::*;
  logic clk_sys, reset_n, bat_above_pon, bat_below_poff, vcc_under, io_supply_under;
  logic temp_above_warn, temp_above_act, temp_below_rel, bus_wake_std, bus_wake_sel;
  logic local_wake_pin, selective_config_valid, bus_rx_bit, rxd_out, tx_enable, rx_enable;
  logic bus_float, wake_selective_mode, regulator_inhibit_out, regulator_inhibit_oe_n;
  logic spi_sck, spi_select_n, spi_sdi, spi_sdo, spi_sdo_oe_n;
  int err_total = 0;
  int check_count = 0;

  ctmc_mode_ctrl uut (.clk_sys, .reset_n, .bat_above_pon, .bat_below_poff, .vcc_under,
    .io_supply_under, .temp_above_warn, .temp_above_act, .temp_below_rel, .bus_wake_std,
    .bus_wake_sel, .local_wake_pin, .selective_config_valid, .bus_rx_bit, .rxd_out,
    .tx_enable, .rx_enable, .bus_float, .wake_selective_mode, .regulator_inhibit_out,
    .regulator_inhibit_oe_n, .spi_sck, .spi_select_n, .spi_sdi, .spi_sdo, .spi_sdo_oe_n);

  ctmc_host_model host (.spi_sck, .spi_select_n, .spi_sdi, .spi_sdo, .spi_sdo_oe_n);

  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic bit_is(input logic got, input logic exp);
    cmp({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({a, 1'b0, d}, r);
    @(negedge clk_sys);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer({a, 1'b1, 8'h00}, r);
    @(negedge clk_sys);
    cmp(r, e);
  endtask

  // Bounded wait on the inhibit enable; running out ends the run
  task automatic wait_inh(input logic e);
    int n;
    n = 0;
    while (regulator_inhibit_oe_n !== e && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    bit_is(regulator_inhibit_oe_n, e);
    if (n == 400) finish_test();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power_up();
    logic [7:0] r;
    bit_is(bus_float, 1'b1);
    bit_is(regulator_inhibit_oe_n, 1'b1);
    host.xfer({ADDR_MODE, 1'b1, 8'h00}, r);
    cyc(1);
    bit_is(host.oe_seen, 1'b0);
    bat_above_pon = 1'b1;
    cyc(50);
    bit_is(regulator_inhibit_oe_n, 1'b1);
    wait_inh(1'b0);
    bit_is(regulator_inhibit_out, 1'b1);
    rdc(ADDR_MODE, 8'h04);
    bit_is(host.oe_seen, 1'b1);
    rdc(ADDR_STATUS, 8'h20);
  endtask

  task automatic t_normal();
    wr(ADDR_XCVR_CTRL, 8'h02);
    wr(ADDR_MODE, 8'hFF);
    rdc(ADDR_MODE, 8'h07);
    bit_is(tx_enable, 1'b1);
    bit_is(rx_enable, 1'b1);
    bus_rx_bit = 1'b0;
    cyc(5);
    bit_is(rxd_out, 1'b0);
    bus_rx_bit = 1'b1;
    cyc(5);
    bit_is(rxd_out, 1'b1);
    wr(ADDR_XCVR_CTRL, 8'h00);
    bus_rx_bit = 1'b0;
    cyc(5);
    bit_is(rxd_out, 1'b1);
    bus_rx_bit = 1'b1;
    rdc(ADDR_STATUS, 8'h00);
    wr(ADDR_MODE, 8'h04);
    rdc(ADDR_MODE, 8'h04);
  endtask

  task automatic t_sleep_wake();
    wr(ADDR_MODE, 8'h01);
    rdc(ADDR_MODE, 8'h04);
    wr(ADDR_WAKE_CFG, 8'h03);
    selective_config_valid = 1'b1;
    cyc(5);
    bit_is(wake_selective_mode, 1'b1);
    wr(ADDR_MODE, 8'h01);
    wait_inh(1'b1);
    bus_wake_std = 1'b1;
    cyc(10);
    bit_is(regulator_inhibit_oe_n, 1'b1);
    bus_wake_sel = 1'b1;
    wait_inh(1'b0);
    {bus_wake_std, bus_wake_sel} = 2'h0;
    wr(ADDR_EVENTS, 8'h01);
    selective_config_valid = 1'b0;
    cyc(5);
    bit_is(wake_selective_mode, 1'b0);
    wr(ADDR_MODE, 8'h01);
    wait_inh(1'b1);
    rdc(ADDR_WAKE_CFG, 8'h03);
    wait_inh(1'b0);
    rdc(ADDR_STATUS, 8'h00);
    wr(ADDR_MODE, 8'h01);
    wait_inh(1'b1);
    bit_is(rxd_out, 1'b1);
    host.xfer8(8'h03);
    cyc(5);
    bit_is(regulator_inhibit_oe_n, 1'b1);
    bus_wake_std = 1'b1;
    wait_inh(1'b0);
    bit_is(rxd_out, 1'b0);
    bus_wake_std = 1'b0;
    rdc(ADDR_EVENTS, 8'h05);
    wr(ADDR_EVENTS, 8'h05);
    cyc(5);
    bit_is(rxd_out, 1'b1);
  endtask

  task automatic t_undervoltage();
    logic [7:0] r;
    wr(ADDR_WAKE_CFG, 8'h02);
    vcc_under = 1'b1;
    wait_inh(1'b1);
    vcc_under = 1'b0;
    cyc(5);
    rdc(ADDR_STATUS, 8'h80);
    rdc(ADDR_WAKE_CFG, 8'h0D);
    rdc(ADDR_EVENTS, 8'h00);
    io_supply_under = 1'b1;
    wait_inh(1'b1);
    host.xfer({ADDR_MODE, 1'b1, 8'h00}, r);
    cyc(1);
    bit_is(host.oe_seen, 1'b0);
    bit_is(regulator_inhibit_oe_n, 1'b1);
    io_supply_under = 1'b0;
    local_wake_pin = 1'b1;
    wait_inh(1'b0);
    rdc(ADDR_EVENTS, 8'h01);
    wr(ADDR_MODE, 8'h01);
    rdc(ADDR_MODE, 8'h04);
    wr(ADDR_EVENTS, 8'h01);
  endtask

  task automatic t_overtemp();
    logic [7:0] r;
    wr(ADDR_WAKE_CFG, 8'h11);
    wr(ADDR_XCVR_CTRL, 8'h02);
    wr(ADDR_MODE, 8'h07);
    temp_above_warn = 1'b1;
    cyc(5);
    rdc(ADDR_STATUS, 8'hC0);
    rdc(ADDR_EVENTS, 8'h02);
    wr(ADDR_EVENTS, 8'h02);
    bus_wake_std = 1'b1;
    cyc(5);
    bus_wake_std = 1'b0;
    temp_above_act = 1'b1;
    cyc(5);
    bit_is(bus_float, 1'b1);
    bit_is(tx_enable, 1'b0);
    bit_is(rx_enable, 1'b0);
    bit_is(rxd_out, 1'b0);
    host.xfer({ADDR_MODE, 1'b1, 8'h00}, r);
    cyc(1);
    bit_is(host.oe_seen, 1'b0);
    temp_above_act = 1'b0;
    temp_above_warn = 1'b0;
    temp_below_rel = 1'b1;
    cyc(5);
    bit_is(bus_float, 1'b0);
    bit_is(regulator_inhibit_oe_n, 1'b0);
    bit_is(rxd_out, 1'b0);
    rdc(ADDR_MODE, 8'h04);
    wr(ADDR_EVENTS, 8'h01);
    cyc(5);
    bit_is(rxd_out, 1'b1);
  endtask

  task automatic t_power_off();
    bat_below_poff = 1'b1;
    cyc(5);
    bit_is(bus_float, 1'b1);
    bit_is(regulator_inhibit_oe_n, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    {bat_above_pon, bat_below_poff, vcc_under, io_supply_under} = 4'h0;
    {temp_above_warn, temp_above_act, temp_below_rel, bus_wake_std} = 4'h0;
    {bus_wake_sel, local_wake_pin, selective_config_valid} = 3'h0;
    bus_rx_bit = 1'b1;
    cyc(16);
    bit_is(rxd_out, 1'b1);
    reset_n = 1'b1;
    cyc(4);
    t_power_up();
    t_normal();
    t_sleep_wake();
    t_undervoltage();
    t_overtemp();
    t_power_off();
    finish_test();
  end

  // Watchdog against a hung handshake
  initial begin
    #900000;
    err_total++;
    finish_test();
  end
endmodule
